// File: src/usf_pkg.sv
package usf_pkg;

  // Printed offsets are word indices; byte address is four times the index.
  localparam logic [3:0]  USF_IDX_DEV_SUMMARY = 4'h0;
  localparam logic [3:0]  USF_IDX_UNIT_STATUS = 4'h1;
  localparam logic [3:0]  USF_IDX_IRQ_STATUS  = 4'h2;
  localparam logic [3:0]  USF_IDX_IRQ_MASK    = 4'h3;
  localparam logic [3:0]  USF_IDX_RAW_CTRL    = 4'h4;
  localparam logic [5:0]  USF_ADR_DEV_SUMMARY = {USF_IDX_DEV_SUMMARY, 2'h0};
  localparam logic [5:0]  USF_ADR_UNIT_STATUS = {USF_IDX_UNIT_STATUS, 2'h0};
  localparam logic [5:0]  USF_ADR_IRQ_STATUS  = {USF_IDX_IRQ_STATUS, 2'h0};
  localparam logic [5:0]  USF_ADR_IRQ_MASK    = {USF_IDX_IRQ_MASK, 2'h0};
  localparam logic [5:0]  USF_ADR_RAW_CTRL    = {USF_IDX_RAW_CTRL, 2'h0};

  // Unit status word field positions.
  localparam int USF_POS_WRITE_MODE = 20;
  localparam int USF_POS_RAM_DIRTY  = 21;
  localparam int USF_POS_COMM_WRITE = 25;

  // Device summary word field positions.
  localparam int USF_POS_DEV_ERR  = 0;
  localparam int USF_POS_CFG_ERR  = 1;
  localparam int USF_POS_XRAM_ERR = 3;
  localparam int USF_POS_INT_COMM = 4;
  localparam int USF_POS_LINK_ERR = 6;

  localparam logic [15:0] USF_MASK_RESET = 16'h0000;
  localparam logic [31:0] USF_CTRL_RESET = 32'h0000_0000;

  localparam logic [1:0]  USF_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  USF_HSIZE_WORD    = 3'h2;

  // Status and error sources from the rest of the unit, before synchronisation.
  typedef struct packed {
    logic       write_mode_ram;
    logic       ram_dirty;
    logic [4:0] dev_err_bits;
    logic       left_unit;
    logic       other_cfg_err;
    logic       xram_err;
    logic [3:0] link_err_bits;
  } usf_src_s;

  localparam int USF_SRC_W = $bits(usf_src_s);

endpackage

// File: src/usf_sync.sv
`timescale 1ns/1ps
module usf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Only the second stage reads the first, to contain metastability.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: src/usf_top.sv
// Functional notes
// - bit 20 shows RAM write mode.
// - bit 21 shows unsaved RAM changes.
// - bit 25 always reads one.
// - bit 0 summarises device memory errors.
// - bit 1 summarises configuration errors.
// - bit 3 shows external RAM error.
// - bit 4 set by any link error.
// - bit 6 shows link error present.
// - left-side unit counts as configuration error.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module usf_top (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Status sources, asynchronous to hclk
  input  wire usf_pkg::usf_src_s src_in,
  // Interrupt
  output logic                  irq
);
  import usf_pkg::*;

  usf_src_s    src;
  logic [15:0] dev_word;
  logic [31:0] unit_word;
  logic [15:0] irq_status;
  logic [15:0] irq_mask;
  logic [31:0] raw_ctrl;
  logic [15:0] dev_prev;
  logic [15:0] rise;
  logic        dp_valid;
  logic        dp_write;
  logic [5:0]  dp_addr;
  logic        rd_irq_status;
  logic        mapped;
  logic [31:0] next_rdata;
  logic        addr_take;
  usf_src_s    eff;

  usf_sync #(.WIDTH(USF_SRC_W)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (src_in),
    .sync_out (src)
  );

  // Software may force sources high through the control register, for bring-up.
  always_comb begin
    eff = src | usf_src_s'(raw_ctrl[USF_SRC_W-1:0]);
  end

  // Both words are registered so a read sees one consistent snapshot.
  // The price is one more edge of latency from a source to the bus.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_word <= 32'h0000_0000;
    end else begin
      unit_word                     <= 32'h0000_0000;
      unit_word[USF_POS_WRITE_MODE] <= eff.write_mode_ram;
      unit_word[USF_POS_RAM_DIRTY]  <= eff.ram_dirty;
      unit_word[USF_POS_COMM_WRITE] <= 1'b1;
    end
  end

  // Bits 4 and 6 both follow the OR of the link errors, so software cannot tell them apart.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_word <= 16'h0000;
    end else begin
      dev_word                      <= 16'h0000;
      dev_word[USF_POS_DEV_ERR]     <= |eff.dev_err_bits;
      dev_word[USF_POS_CFG_ERR]     <= eff.left_unit | eff.other_cfg_err;
      dev_word[USF_POS_XRAM_ERR]    <= eff.xram_err;
      dev_word[USF_POS_INT_COMM]    <= |eff.link_err_bits;
      dev_word[USF_POS_LINK_ERR]    <= |eff.link_err_bits;
    end
  end

  // Bus address phase capture.
  assign addr_take = hsel && hready && (htrans == USF_HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 6'h00;
    end else if (hready) begin
      dp_valid <= addr_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[5:0];
    end
  end

  always_comb begin
    mapped     = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (dp_addr)
      USF_ADR_DEV_SUMMARY: next_rdata = {16'h0000, dev_word};
      USF_ADR_UNIT_STATUS: next_rdata = unit_word;
      USF_ADR_IRQ_STATUS:  next_rdata = {16'h0000, irq_status};
      USF_ADR_IRQ_MASK:    next_rdata = {16'h0000, irq_mask};
      USF_ADR_RAW_CTRL:    next_rdata = raw_ctrl;
      default:             mapped     = 1'b0;
    endcase
  end

  // Reads take one wait state so hrdata comes straight from a flip-flop.
  // The cost is a second cycle per read; writes finish without waiting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (!hreadyout) begin
      hreadyout <= 1'b1;
      hrdata    <= mapped ? next_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Writes to status words land nowhere, which keeps them read-only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= USF_MASK_RESET;
    end else if (dp_valid && dp_write && (dp_addr == USF_ADR_IRQ_MASK)) begin
      irq_mask <= hwdata[15:0];
    end
  end

  // Forcing acts on the synchronised sources, so forced bits skip the synchroniser but take the same path as real ones after it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_ctrl <= USF_CTRL_RESET;
    end else if (dp_valid && dp_write && (dp_addr == USF_ADR_RAW_CTRL)) begin
      raw_ctrl <= {{(32-USF_SRC_W){1'b0}}, hwdata[USF_SRC_W-1:0]};
    end
  end

  // Sticky events on rising summary bits; a new event beats the read clear.
  assign rise          = dev_word & ~dev_prev;
  assign rd_irq_status = dp_valid && !dp_write && !hreadyout && (dp_addr == USF_ADR_IRQ_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_prev <= 16'h0000;
    end else begin
      dev_prev <= dev_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 16'h0000;
    end else begin
      irq_status <= (rd_irq_status ? 16'h0000 : irq_status) | rise;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  a_comm_write_one: assert property (
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> unit_word[USF_POS_COMM_WRITE])
    else $error("Communications writing bit not one.");

  a_unit_unused_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (unit_word & ~32'h0230_0000) == 32'h0000_0000)
    else $error("Unused unit status bit set.");

  a_dev_unused_zero: assert property (
    @(posedge hclk) disable iff (!hresetn) (dev_word & ~16'h005B) == 16'h0000)
    else $error("Unused device status bit set.");

  a_write_mode_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 unit_word[USF_POS_WRITE_MODE] == $past(eff.write_mode_ram))
    else $error("Write mode bit wrong.");

  a_ram_dirty_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 unit_word[USF_POS_RAM_DIRTY] == $past(eff.ram_dirty))
    else $error("RAM dirty bit wrong.");

  a_dev_err_summary: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 dev_word[USF_POS_DEV_ERR] == |$past(eff.dev_err_bits))
    else $error("Device error summary wrong.");

  a_left_unit_cfg: assert property (
    @(posedge hclk) disable iff (!hresetn) eff.left_unit |=> dev_word[USF_POS_CFG_ERR])
    else $error("Left unit did not flag configuration error.");

  a_cfg_err_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !eff.left_unit && !eff.other_cfg_err |=> !dev_word[USF_POS_CFG_ERR])
    else $error("Configuration error without cause.");

  a_xram_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 dev_word[USF_POS_XRAM_ERR] == $past(eff.xram_err))
    else $error("External RAM error bit wrong.");

  a_link_sets_comm: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dev_word[USF_POS_LINK_ERR] |-> dev_word[USF_POS_INT_COMM])
    else $error("Link error without internal comm bit.");

  a_link_err_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 dev_word[USF_POS_LINK_ERR] == |$past(eff.link_err_bits))
    else $error("Link error bit wrong.");

  a_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn) |(irq_status & irq_mask) |=> irq)
    else $error("Interrupt not raised.");

  // Each summary bit follows its sources one edge later.
  a_int_comm_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 dev_word[USF_POS_INT_COMM] == |$past(eff.link_err_bits))
    else $error("Internal communications bit wrong.");

  a_cfg_err_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 dev_word[USF_POS_CFG_ERR] == ($past(eff.left_unit) | $past(eff.other_cfg_err)))
    else $error("Configuration error bit wrong.");

  // Bus timing: one wait state per read, none per write.
  a_read_wait: assert property (
    @(posedge hclk) disable iff (!hresetn) addr_take && !hwrite |=> !hreadyout)
    else $error("Read did not insert its wait state.");

  a_read_one_wait: assert property (
    @(posedge hclk) disable iff (!hresetn) !hreadyout |=> hreadyout)
    else $error("Read wait state too long.");

  a_write_no_wait: assert property (
    @(posedge hclk) disable iff (!hresetn) addr_take && hwrite |=> hreadyout)
    else $error("Write inserted a wait state.");

  a_dp_hold: assert property (
    @(posedge hclk) disable iff (!hresetn) !hready |=> $stable(dp_addr))
    else $error("Data phase address moved during a wait.");

  a_read_data: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hreadyout && mapped |=> hrdata == $past(next_rdata))
    else $error("Read data not the addressed register.");

  a_unmapped_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hreadyout && !mapped |=> hrdata == 32'h0000_0000)
    else $error("Unmapped read not zero.");

  a_rdata_stable: assert property (
    @(posedge hclk) disable iff (!hresetn) hreadyout |=> $stable(hrdata))
    else $error("Read data moved between reads.");

  a_resp_okay: assert property (
    @(posedge hclk) disable iff (!hresetn) !hresp)
    else $error("Response not OKAY.");

  // Interrupt bookkeeping: a set beats the read clear, and nothing else drops a bit.
  a_status_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rd_irq_status |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("Status bit dropped without a read.");

  a_read_clears: assert property (
    @(posedge hclk) disable iff (!hresetn) rd_irq_status |=> irq_status == $past(rise))
    else $error("Status read did not clear.");

  a_event_sets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rise != 16'h0000 |=> (irq_status & $past(rise)) == $past(rise))
    else $error("Event did not set its status bit.");

  a_irq_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (irq_status & irq_mask) == 16'h0000 |=> !irq)
    else $error("Interrupt without unmasked cause.");

  a_irq_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq |-> ($past(irq_status) & $past(irq_mask)) != 16'h0000)
    else $error("Interrupt high with no earlier cause.");

  // Writable registers change only on their own write.
  a_mask_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dp_valid && dp_write && (dp_addr == USF_ADR_IRQ_MASK)
    |=> {16'h0000, irq_mask} == ($past(hwdata) & 32'h0000_FFFF))
    else $error("Mask write not taken.");

  a_mask_hold: assert property (
    @(posedge hclk) disable iff (!hresetn) !(dp_valid && dp_write) |=> $stable(irq_mask))
    else $error("Mask changed without a write.");

  a_ctrl_hold: assert property (
    @(posedge hclk) disable iff (!hresetn) !(dp_valid && dp_write) |=> $stable(raw_ctrl))
    else $error("Control changed without a write.");

  c_read_unit: cover property (
    @(posedge hclk) disable iff (!hresetn)
    dp_valid && !dp_write && dp_addr == USF_ADR_UNIT_STATUS ##1 hreadyout);

  c_link_error: cover property (
    @(posedge hclk) disable iff (!hresetn) $rose(dev_word[USF_POS_LINK_ERR]));

  c_irq_fire: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));

  c_word_write: cover property (
    @(posedge hclk) disable iff (!hresetn) addr_take && hwrite && (hsize == USF_HSIZE_WORD));

  c_clear_race: cover property (
    @(posedge hclk) disable iff (!hresetn)
    rd_irq_status && (rise != 16'h0000));

endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import usf_pkg::*;
  logic          hclk;
  logic          hresetn;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [2:0]    hsize;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          hresp;
  usf_src_s      src_in;
  logic          irq;
  logic          rdy_s;
  logic [31:0]   rd_s;
  logic [31:0]   rd;
  logic [31:0]   ctrl;
  logic [13:0]   rnd;
  logic          irq_s;
  logic          rsp_s;
  int            fail_count;
  int            comparisons;
  int            cycles;

  usf_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_in(src_in), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Outputs only move on rising edges, so a mid-cycle copy is what the next edge samples.
  always @(negedge hclk) begin
    rdy_s <= hreadyout;
    rd_s  <= hrdata;
    irq_s <= irq;
    rsp_s <= hresp;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Entered just after a rising edge; returns just after the edge ending the data phase.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rdata);
    hsel   <= 1'b1;
    htrans <= USF_HTRANS_NONSEQ;
    haddr  <= {26'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    rdata = rd_s;
    check("hresp", 32'h0, {31'h0, rsp_s});
  endtask

  function automatic logic [31:0] exp_dev(input usf_src_s s);
    exp_dev = 32'h0;
    exp_dev[USF_POS_DEV_ERR]  = |s.dev_err_bits;
    exp_dev[USF_POS_CFG_ERR]  = s.left_unit | s.other_cfg_err;
    exp_dev[USF_POS_XRAM_ERR] = s.xram_err;
    exp_dev[USF_POS_INT_COMM] = |s.link_err_bits;
    exp_dev[USF_POS_LINK_ERR] = |s.link_err_bits;
  endfunction

  function automatic logic [31:0] exp_unit(input usf_src_s s);
    exp_unit = 32'h0;
    exp_unit[USF_POS_WRITE_MODE] = s.write_mode_ram;
    exp_unit[USF_POS_RAM_DIRTY]  = s.ram_dirty;
    exp_unit[USF_POS_COMM_WRITE] = 1'b1;
  endfunction

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = USF_HSIZE_WORD;
    hwdata = 32'h0;
    src_in = '0;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(32'h2725));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, USF_ADR_DEV_SUMMARY, 32'h0, rd);
    check("dev_reset", 32'h0, rd);
    bus(1'b0, USF_ADR_UNIT_STATUS, 32'h0, rd);
    check("unit_reset", 32'h0200_0000, rd);
    for (int i = 0; i < 24; i++) begin
      rnd = 14'($urandom);
      if (i == 0) rnd = 14'h0000;
      if (i == 1) rnd = 14'h3FFF;
      if (i == 2) rnd = 14'h0040;
      ctrl = (i >= 14) ? {18'h0, 14'($urandom)} : 32'h0;
      bus(1'b1, USF_ADR_RAW_CTRL, ctrl, rd);
      src_in <= rnd;
      bus(1'b1, USF_ADR_DEV_SUMMARY, $urandom, rd);
      bus(1'b1, USF_ADR_UNIT_STATUS, $urandom, rd);
      repeat (4) @(posedge hclk);
      bus(1'b0, USF_ADR_DEV_SUMMARY, 32'h0, rd);
      check("dev_summary", exp_dev(rnd | ctrl[13:0]), rd);
      bus(1'b0, USF_ADR_UNIT_STATUS, 32'h0, rd);
      check("unit_status", exp_unit(rnd | ctrl[13:0]), rd);
    end
    bus(1'b0, 6'h3C, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    bus(1'b1, USF_ADR_RAW_CTRL, 32'h0, rd);
    src_in <= '0;
    repeat (6) @(posedge hclk);
    bus(1'b0, USF_ADR_IRQ_STATUS, 32'h0, rd);
    bus(1'b1, USF_ADR_IRQ_MASK, 32'h1, rd);
    // A masked event must stay silent, an unmasked one must raise the line.
    src_in <= 14'h0040;
    repeat (6) @(posedge hclk);
    check("irq_masked", 32'h0, {31'h0, irq_s});
    src_in <= 14'h0240;
    repeat (6) @(posedge hclk);
    check("irq_raised", 32'h1, {31'h0, irq_s});
    bus(1'b0, USF_ADR_IRQ_STATUS, 32'h0, rd);
    check("irq_status", 32'h3, rd);
    repeat (3) @(posedge hclk);
    check("irq_cleared", 32'h0, {31'h0, irq_s});
    bus(1'b0, USF_ADR_IRQ_STATUS, 32'h0, rd);
    check("irq_status_clr", 32'h0, rd);
    summarize();
  end
endmodule
